// >>> sbp_bank.sv
// Bank of eight six-bit modulators plus the stagger stage of the hi-res output.
// Assumes a processor special-function write/read port on the same clock and
// port latches and the hi-res modulator level from logic on that clock.
`include "sbp_cfg.svh"

module sbp_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic [7:0] sfr_wdata,
  output logic sfr_hit,
  output logic [7:0] sfr_rdata,
  // Port latches sharing the pins
  input wire logic [7:0] port0_latch,
  input wire logic port1_bit3_latch,
  // High-resolution modulator link
  input wire logic hires_enable,
  input wire logic hires_level,
  output logic ctr_tick,
  output logic [`SBP_CTR_W-1:0] ctr_value,
  // Open-drain pins
  output sbp_pkg::sbp_pin_s [7:0] port0_pin,
  output sbp_pkg::sbp_pin_s port1_bit3_pin
);

  // Eight lo-res channels; the hi-res output is instanced on its own
  localparam int NCH = 8;

  logic [1:0] pre_q;
  logic [`SBP_CTR_W-1:0] ctr_q;
  logic [`SBP_CTR_W-1:0] ctr_next;
  logic tick;
  sbp_pkg::sbp_chan_s ctrl_q [NCH];
  logic [NCH-1:0] sel;
  logic [2:0] sel_idx;
  logic [7:0] rd_d;
  logic [7:0] rdata_q;
  sbp_pkg::sbp_pin_s chan_pin [NCH];
  sbp_pkg::sbp_chan_s hires_ctrl;
  logic lo_blk;
  logic hi_blk;

  // Counter clock enable: every fourth processor clock
  assign tick = (pre_q == `SBP_PRE_LAST);
  // Next count feeds the compares so each output flop lines up with the count
  assign ctr_next = ctr_q + `SBP_CTR_W'(1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 2'h0;
    end else begin
      pre_q <= pre_q + 2'h1;
    end
  end

  // Shared counter, cleared by reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctr_q <= '0;
    end else if (tick) begin
      ctr_q <= ctr_next;
    end
  end

  assign ctr_tick = tick;
  assign ctr_value = ctr_q;

  // Register decode: channels 0-3 low block, 4-7 high block
  // Each block spans four addresses, so the top six bits pick the block
  assign lo_blk = (sfr_addr[7:2] == 6'(`SBP_ADDR_LO >> 2));
  assign hi_blk = (sfr_addr[7:2] == 6'(`SBP_ADDR_HI >> 2));
  assign sel_idx = {hi_blk, sfr_addr[1:0]};
  assign sfr_hit = lo_blk || hi_blk;

  // Per-channel control register and output
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign sel[i] = sfr_hit && (sel_idx == 3'(i));

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_q[i] <= '0;
        end else if (sfr_we && sel[i]) begin
          ctrl_q[i].en <= sfr_wdata[`SBP_EN_BIT];
          ctrl_q[i].duty <= sfr_wdata[`SBP_DUTY_MSB:0];
        end
      end

      sbp_chan #(
        .DELAY(i / 3),
        .HIRES(1'b0)
      ) u_chan (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick),
        .ctr_next(ctr_next),
        .ctrl(ctrl_q[i]),
        .hires_level(1'b0),
        .latch_bit((i == 0) ? port1_bit3_latch : port0_latch[i]),
        .pin(chan_pin[i])
      );
    end
  endgenerate

  // Hi-res output joins the two-clock-delay group
  // Its duty field is unused: the level arrives ready-made from outside
  assign hires_ctrl = '{en: hires_enable, duty: '0};

  sbp_chan #(
    .DELAY(`SBP_DLY_TWO),
    .HIRES(1'b1)
  ) u_hires (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick),
    .ctr_next(ctr_next),
    .ctrl(hires_ctrl),
    .hires_level(hires_level),
    .latch_bit(port0_latch[0]),
    .pin(port0_pin[0])
  );

  // Pin map: channel 0 on port 1 bit 3, channels 1-7 on port 0 bits 1-7
  assign port1_bit3_pin = chan_pin[0];
  generate
    for (genvar p = 1; p < NCH; p++) begin : g_pin
      assign port0_pin[p] = chan_pin[p];
    end
  endgenerate

  // Read data: reserved bit 6 reads zero, unmapped reads zero
  assign rd_d = sfr_hit ? {ctrl_q[sel_idx].en, 1'b0, ctrl_q[sel_idx].duty} : 8'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_d;
    end
  end

  assign sfr_rdata = rdata_q;

  // Checks
  // Three idle clocks separate consecutive counter clocks
  sequence s_quiet3;
    !tick [*3];
  endsequence

  // Prescaler: exactly one counter clock in every four processor clocks
  AST_TICK_EVERY_FOUR: assert property (@(posedge clock) disable iff (!rst_n)
    tick |=> s_quiet3 ##1 tick)
    else $error("Counter clock is not one in four");

  // Counter advances by one on each counter clock and holds in between
  AST_CTR_STEP: assert property (@(posedge clock) disable iff (!rst_n)
    tick |=> ctr_q == $past(ctr_q) + 6'h01)
    else $error("Shared counter did not advance");

  AST_CTR_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !tick |=> $stable(ctr_q))
    else $error("Counter moved off the counter clock");

  // A full count wraps back to zero, giving the sixty-four clock period
  AST_PERIOD_64: assert property (@(posedge clock) disable iff (!rst_n)
    tick && ctr_q == 6'h3f |=> ctr_q == 6'h00)
    else $error("Counter period is not sixty-four");

  // A write to channel 3's address lands in that channel's register
  AST_WRITE_TAKES: assert property (@(posedge clock) disable iff (!rst_n)
    sfr_we && sel[3] |=> ctrl_q[3].duty == $past(sfr_wdata[5:0]) &&
    ctrl_q[3].en == $past(sfr_wdata[7]))
    else $error("Control write not stored");

  // Writes outside both blocks leave the control registers of channels 0 and 7 alone
  AST_STRAY_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    sfr_we && !sfr_hit |=> $stable(ctrl_q[0]) && $stable(ctrl_q[7]))
    else $error("Unmapped write changed a control register");

  // Read data lags the address by one clock and bit 6 reads zero
  AST_READ_LAG: assert property (@(posedge clock) disable iff (!rst_n)
    sel[2] |=> sfr_rdata == {$past(ctrl_q[2].en), 1'b0, $past(ctrl_q[2].duty)})
    else $error("Read data does not show the addressed register");

  // First clock after reset: channel 5 is disabled with zero duty so the port owns its pin, counter at zero
  AST_RESET_OWNER: assert property (@(posedge clock)
    $rose(rst_n) |-> !ctrl_q[5].en && ctrl_q[5].duty == 6'h00)
    else $error("Channel owns pin after reset");

  AST_RESET_CTR: assert property (@(posedge clock)
    $rose(rst_n) |-> ctr_q == 6'h00 && pre_q == 2'h0)
    else $error("Counter not cleared by reset");

  // Every channel register comes out of reset disabled with zero duty
  generate
    for (genvar r = 0; r < NCH; r++) begin : g_rst_chk
      AST_RESET_CLEAR: assert property (@(posedge clock)
        $rose(rst_n) |-> ctrl_q[r] == '0)
        else $error("Channel register not cleared by reset");
    end
  endgenerate

  // Channel 0 sits on port 1 bit 3 and follows that latch while disabled
  AST_CH0_PIN: assert property (@(posedge clock) disable iff (!rst_n)
    rst_n && !ctrl_q[0].en |=> port1_bit3_pin.oe == !$past(port1_bit3_latch))
    else $error("Channel pin map wrong");

  // Channels 1-7 sit on the port 0 bit of the same number
  generate
    for (genvar p = 1; p < NCH; p++) begin : g_map_chk
      AST_P0_PIN: assert property (@(posedge clock) disable iff (!rst_n)
        rst_n && !ctrl_q[p].en |=> port0_pin[p].oe == !$past(port0_latch[p]))
        else $error("Port 0 pin map wrong");
    end
  endgenerate

  // Port 0 bit 0 follows its latch while the hi-res modulator is off
  AST_HIRES_OWNER: assert property (@(posedge clock) disable iff (!rst_n)
    rst_n && !hires_enable |=> port0_pin[0].oe == !$past(port0_latch[0]))
    else $error("Hi-res pin does not follow port latch");

endmodule

// >>> sbp_cfg.svh
// Constants for the six-bit modulator bank: register addresses, field positions,
// reset values and timing counts. Assumes a 100 MHz processor clock.
`ifndef SBP_CFG_SVH
`define SBP_CFG_SVH

// Prescaler terminal count: divide by four
`define SBP_PRE_LAST 2'h3
// Counter width and period in counter clocks
`define SBP_CTR_W 6
`define SBP_PERIOD 64
// Register addresses: channels 0-3 then 4-7
`define SBP_ADDR_LO 8'hd4
`define SBP_ADDR_HI 8'hdc
// Control register fields
`define SBP_EN_BIT 7
`define SBP_DUTY_MSB 5
// Reset value of each control register
`define SBP_CTRL_RST 8'h00
// Edge delays in counter clocks per group
`define SBP_DLY_NONE 0
`define SBP_DLY_ONE 1
`define SBP_DLY_TWO 2

`endif

// >>> sbp_pkg.sv
// Types shared by the six-bit modulator bank.
// Assumes sbp_cfg.svh for field widths.
`include "sbp_cfg.svh"

package sbp_pkg;

  // One channel control register
  typedef struct packed {
    logic en;
    logic [`SBP_CTR_W-1:0] duty;
  } sbp_chan_s;

  // Open-drain pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } sbp_pin_s;

endpackage

// >>> sbp_chan.sv
// One modulator output: compare flip-flop, edge-delay stage and pin select.
// Assumes tick and ctr_next come from the shared counter in the same clock.
`include "sbp_cfg.svh"

module sbp_chan #(
  parameter int DELAY = 0,
  parameter bit HIRES = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Shared counter
  input wire logic tick,
  input wire logic [`SBP_CTR_W-1:0] ctr_next,
  // Control and alternate sources
  input wire sbp_pkg::sbp_chan_s ctrl,
  input wire logic hires_level,
  input wire logic latch_bit,
  // Pin
  output sbp_pkg::sbp_pin_s pin
);

  logic raw_q;
  logic raw_d;
  logic [1:0] dly_q;
  logic level;
  logic oe_q;
  logic match;
  logic wrap;

  // Compare and wrap decode
  assign match = (ctr_next == ctrl.duty);
  assign wrap = (ctr_next == '0);
  // Clear wins over set, so a zero duty stays low all period
  assign raw_d = HIRES ? hires_level :
                 (match ? 1'b0 :
                 (wrap ? 1'b1 : raw_q));
  // Delayed copies picked by group
  assign level = (DELAY == `SBP_DLY_NONE) ? raw_q :
                 (DELAY == `SBP_DLY_ONE) ? dly_q[0] : dly_q[1];

  // Output flip-flop and delay line step on the counter clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      raw_q <= 1'b0;
      dly_q <= 2'h0;
    end else if (tick) begin
      raw_q <= raw_d;
      dly_q <= {dly_q[0], raw_q};
    end
  end

  // Pin owner: channel when enabled, port latch otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ctrl.en ? ~level : ~latch_bit;
    end
  end

  assign pin.out = 1'b0;
  assign pin.oe = oe_q;

  generate
    if (!HIRES) begin : g_chk
      AST_DUTY_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        tick && match |=> !raw_q)
        else $error("Output not cleared on duty match");
      AST_WRAP_SET: assert property (@(posedge clock) disable iff (!rst_n)
        tick && wrap && ctrl.duty != '0 |=> raw_q)
        else $error("Output not set on counter wrap");
    end
  endgenerate

  // Three counter clocks seen, so the delay line holds settled history
  sequence s_three_ticks;
    tick ##1 (!tick [*3]) ##1 tick ##1 (!tick [*3]) ##1 tick;
  endsequence

  AST_EDGE_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    s_three_ticks |-> level == $past(raw_q, 1 + 4 * DELAY))
    else $error("Output edge delay wrong for group");

  // The owner flop lags the latch by one clock; skip the release edge
  AST_PIN_OWNER: assert property (@(posedge clock) disable iff (!rst_n)
    rst_n && !ctrl.en |=> pin.oe == !$past(latch_bit))
    else $error("Disabled channel does not follow port latch");

endmodule

// >>> sbp_integrator.sv
// Far-side load of one open-drain pin: pull-up plus an integrator that
// counts released cycles. Assumes the bank's pin struct and the bench clock.
module sbp_integrator (
  // Clock and control
  input wire logic clock,
  input wire logic clear,
  // Pin from the bank
  input wire sbp_pkg::sbp_pin_s pin,
  // Integrated result
  output logic level,
  output logic [15:0] high_cycles
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up wins unless the pin is driven
  assign level = pin.oe ? pin.out : 1'b1;
  // Count cycles spent released
  always_ff @(posedge clock) begin
    if (clear) begin
      high_cycles <= 16'h0000;
    end else begin
      high_cycles <= high_cycles + 16'(level);
    end
  end
endmodule

// >>> sbp_bank_test.sv
// Self-checking bench for the six-bit modulator bank.
// Assumes one integrator load on every pin and a 100 MHz clock.
`include "sbp_cfg.svh"
module sbp_bank_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_we = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] port0_latch = 8'h3c;
  logic port1_bit3_latch = 1'b0;
  logic hires_enable = 1'b0;
  logic hires_level = 1'b1;
  logic clear = 1'b0;
  logic sfr_hit;
  logic [7:0] sfr_rdata;
  logic ctr_tick;
  logic [`SBP_CTR_W-1:0] ctr_value;
  sbp_pkg::sbp_pin_s [7:0] port0_pin;
  sbp_pkg::sbp_pin_s port1_bit3_pin;
  sbp_pkg::sbp_pin_s [8:0] pins;
  logic [8:0] level;
  logic [8:0][15:0] high_cycles;
  int err_total = 0;
  int samples_checked = 0;
  // Index 0-7 is the channel, 8 is the hi-res pin
  assign pins = {port0_pin[0], port0_pin[7:1], port1_bit3_pin};
  for (genvar i = 0; i < 9; i++) begin : g_load
    sbp_integrator u_load (.clock(clock), .clear(clear), .pin(pins[i]), .level(level[i]),
      .high_cycles(high_cycles[i]));
  end
  sbp_bank DUT (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_wdata(sfr_wdata), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata),
    .port0_latch(port0_latch), .port1_bit3_latch(port1_bit3_latch),
    .hires_enable(hires_enable), .hires_level(hires_level), .ctr_tick(ctr_tick),
    .ctr_value(ctr_value), .port0_pin(port0_pin), .port1_bit3_pin(port1_bit3_pin));
  // Clock and a half-duty hi-res source
  initial forever #5 clock = ~clock;
  always @(posedge clock) hires_level <= (ctr_value < 6'h20);
  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] chan_addr(input int n);
    return (n < 4) ? `SBP_ADDR_LO + 8'(n) : `SBP_ADDR_HI + 8'(n - 4);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_we <= 1'b1;
    sfr_wdata <= d;
    @(posedge clock);
    sfr_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    @(posedge clock);
    #1 d = sfr_rdata;
  endtask
  task automatic chk_latch(input string what);
    logic [7:0] oe;
    #1;
    for (int i = 0; i < 8; i++) oe[i] = port0_pin[i].oe;
    chk(what, {8'h00, ~port0_latch}, 16'(oe));
    chk(what, {15'h0000, ~port1_bit3_latch}, 16'(port1_bit3_pin.oe));
  endtask
  task automatic do_reset();
    logic [7:0] d;
    @(posedge clock);
    rst_n <= 1'b0;
    hires_enable <= 1'b0;
    repeat (20) @(posedge clock);
    #1 chk("ctr_value", 16'h0000, 16'(ctr_value));
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk_latch("pin owner after reset");
    for (int n = 0; n < 8; n++) begin
      rd(chan_addr(n), d);
      chk("reset register", 16'h0000, 16'(d));
    end
    $display("do_reset done");
  endtask
  task automatic test_regs();
    logic [7:0] d;
    for (int n = 0; n < 8; n++) wr(chan_addr(n), 8'h40 | 8'(n * 5));
    wr(8'hd8, 8'hff);
    for (int n = 0; n < 8; n++) begin
      rd(chan_addr(n), d);
      chk("sfr_hit", 16'h0001, 16'(sfr_hit));
      chk("readback", 16'(n * 5), 16'(d));
    end
    rd(8'hd8, d);
    chk("unmapped hit", 16'h0000, 16'(sfr_hit));
    chk("unmapped read", 16'h0000, 16'(d));
    @(posedge clock);
    port0_latch <= 8'ha5;
    port1_bit3_latch <= 1'b1;
    repeat (2) @(posedge clock);
    chk_latch("disabled pins");
    $display("test_regs done");
  endtask
  task automatic next_tick(output int gap);
    gap = 0;
    do begin
      @(posedge clock);
      #1 gap++;
    end while (ctr_tick !== 1'b1 && gap < 8);
  endtask
  task automatic test_tick();
    int gap;
    logic [5:0] v;
    next_tick(gap);
    for (int r = 0; r < 3; r++) begin
      v = ctr_value;
      next_tick(gap);
      chk("tick spacing", 16'h0004, 16'(gap));
      chk("counter step", 16'(6'(v + 6'h01)), 16'(ctr_value));
    end
    $display("test_tick done");
  endtask
  task automatic test_duty();
    logic [8:0][7:0] t;
    logic [8:0] prev;
    logic [7:0] cyc;
    @(posedge clock);
    hires_enable <= 1'b1;
    for (int n = 0; n < 8; n++) wr(chan_addr(n), 8'h80 | 8'(63 - 9 * n));
    repeat (300) @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    #1 prev = level;
    t = '0;
    for (int c = 0; c < 256; c++) begin
      @(posedge clock);
      #1 cyc = 8'(c);
      for (int i = 0; i < 9; i++) if (level[i] && !prev[i]) t[i] = cyc;
      prev = level;
    end
    for (int n = 0; n < 8; n++) begin
      chk("high cycles", 16'(4 * (63 - 9 * n)), high_cycles[n]);
    end
    chk("hires high cycles", 16'h0080, high_cycles[8]);
    chk("one clock stagger", 16'h0004, 16'(8'(t[3] - t[0])));
    chk("two clock stagger", 16'h0008, 16'(8'(t[6] - t[0])));
    $display("test_duty done");
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence, reset again at the end
  initial begin
    do_reset();
    test_regs();
    test_tick();
    test_duty();
    do_reset();
    close_out();
  end
  // Watchdog well past the expected seven hundred or so cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    close_out();
  end
endmodule
